// ---- inc/sram_port_pkg.sv ----
/*
 * Shared constants for the pipelined synchronous memory port: default
 * geometry, pipeline depths and reset values.
 * Assumes it is compiled before every interface and module that imports it.
 */
package sram_port_pkg;
    // default geometry: four lanes of eight bits, 256K words
    localparam int unsigned DEF_ADDR_W   = 18;
    localparam int unsigned DEF_LANES    = 4;
    localparam int unsigned BYTE_W       = 8;
    localparam int unsigned PARITY_LANES = 4;      // check bits exist only with this many lanes
    // burst geometry
    localparam int unsigned BURST_LEN    = 4;
    localparam int unsigned BURST_W      = 2;
    // pipeline: write data follows its address by this many enabled edges
    localparam int unsigned WR_DATA_LAG  = 2;
    // read data leaves the output stage this many enabled edges after the address
    localparam int unsigned RD_LATENCY   = 2;
    // output buffer depth
    localparam int unsigned OUT_BUF_DEPTH = 2;
    // reset values
    localparam logic [1:0] BURST_CNT_RST = 2'h0;
    localparam logic       LEVEL_RST     = 1'h0;
    localparam logic       LEVEL_N_RST   = 1'h1;

    // cycle kinds decoded when an address is loaded
    typedef enum logic [1:0] {
        OP_DESEL,
        OP_READ,
        OP_WRITE
    } op_e;
endpackage : sram_port_pkg

// ---- inc/sram_array_if.sv ----
/*
 * Carrier between the port logic and its storage array: one write port with
 * lane enables and one read port with a registered result.
 * Assumes a single clock shared by both ends.
 */
`timescale 1ns/10ps
`default_nettype none
interface sram_array_if #(
    parameter int unsigned ADDR_W = 18,
    parameter int unsigned LANES  = 4,
    parameter int unsigned LANE_W = 9
);
    logic                      we;      // write strobe
    logic [ADDR_W-1:0]         waddr;   // write word address
    logic [LANES*LANE_W-1:0]   wdata;   // write word
    logic [LANES-1:0]          be;      // lane enables, high writes the lane
    logic                      re;      // read strobe
    logic [ADDR_W-1:0]         raddr;   // read word address
    logic [LANES*LANE_W-1:0]   rdata;   // registered read word

    modport ctrl (output we, waddr, wdata, be, re, raddr, input rdata);
    modport store (input we, waddr, wdata, be, re, raddr, output rdata);
endinterface : sram_array_if
`default_nettype wire

// ---- logic/sram_array.sv ----
/*
 * Storage array: one word per address, lane-masked writes, read data from a
 * register one edge after the read strobe.
 * Assumes the port logic never reads and writes the same word in one cycle
 * expecting the new value; a same-cycle read returns the old word.
 */
`timescale 1ns/10ps
`default_nettype none
module sram_array
    import sram_port_pkg::*;
(
    // clock
    input  wire logic   clk_i,
    // array port
    sram_array_if.store port
);
    localparam int unsigned AW = $bits(port.waddr);
    localparam int unsigned LN = $bits(port.be);
    localparam int unsigned LW = $bits(port.wdata) / LN;

    logic [LN*LW-1:0] mem [2**AW];   // no reset: contents are undefined at power-up

    // one process owns the array; each enable gates its own lane only
    always_ff @(posedge clk_i) begin
        for (int g = 0; g < LN; g++) begin
            if (port.we && port.be[g]) begin
                mem[port.waddr][g*LW +: LW] <= port.wdata[g*LW +: LW];
            end
        end
    end

    // registered read
    always_ff @(posedge clk_i) begin
        if (port.re) begin
            port.rdata <= mem[port.raddr];
        end
    end
endmodule : sram_array
`default_nettype wire

// ---- logic/out_buffer.sv ----
/*
 * Small fall-through FIFO for read words between the array and the data
 * pins: an empty buffer passes the fill word straight on, so no cycle is
 * added. Width and depth are parameters; full and empty are exact.
 * Assumes the drain side may stall for any number of cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module out_buffer #(
    parameter int unsigned WIDTH = 36,
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    // fill side
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] slot [DEPTH];   // entries, flops
    logic [PW-1:0]    wr_ptr;         // next slot to fill
    logic [PW-1:0]    rd_ptr;         // head slot
    logic [PW:0]      count;          // entries held
    logic             push;
    logic             pop;

    assign in_ready_o  = (count < (PW+1)'(DEPTH));
    assign out_valid_o = (count != '0) || in_valid_i;
    assign out_data_o  = (count == '0) ? in_data_i : slot[rd_ptr];   // fill word while empty, otherwise the head flop
    // a word taken at once while empty is neither stored nor popped
    assign push        = in_valid_i && in_ready_o && !((count == '0) && out_ready_i);
    assign pop         = (count != '0) && out_ready_i;

    // storage carries no reset, only the pointers and count do
    always_ff @(posedge clk_i) begin
        if (push) begin
            slot[wr_ptr] <= in_data_i;
        end
    end

    // pointers and occupancy
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH-1)) ? '0 : PW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH-1)) ? '0 : PW'(rd_ptr + 1'b1);
            end
            count <= (PW+1)'(count + (PW+1)'(push) - (PW+1)'(pop));
        end
    end

    AST_NO_OVERFLOW: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        count <= (PW+1)'(DEPTH)) else $error("output buffer overfilled");
endmodule : out_buffer
`default_nettype wire

// ---- logic/sram_port.sv ----
/*
 * Pipelined synchronous memory port with late-late write, 2-bit burst
 * counter, lane masking, clock-enable suspend, output enable and snooze.
 * Assumes the controller runs on CORE_CLK_I; output enable, snooze and the
 * burst-order strap are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`default_nettype none
module sram_port
    import sram_port_pkg::*;
#(
    parameter int unsigned ADDR_W    = DEF_ADDR_W,
    parameter int unsigned LANES     = DEF_LANES,
    parameter bit          PARITY_EN = 1'b1,
    localparam int unsigned LANE_W   = BYTE_W + ((PARITY_EN && LANES == PARITY_LANES) ? 1 : 0),
    localparam int unsigned DATA_W   = LANES * LANE_W
) (
    // clock and reset
    input  wire logic              CORE_CLK_I,
    input  wire logic              ARST_N_I,
    // synchronous address and control
    input  wire logic [ADDR_W-1:0] SYNC_ADDR_I,
    input  wire logic              CHIP_SEL_N_I,
    input  wire logic              CHIP_SEL2_N_I,
    input  wire logic              CHIP_SEL_HI_I,
    input  wire logic              LOAD_ADVANCE_N_I,
    input  wire logic              READ_WRITE_N_I,
    input  wire logic              CLK_EN_N_I,
    input  wire logic [LANES-1:0]  BYTE_WR_N_I,
    // asynchronous controls
    input  wire logic              BURST_ORDER_I,
    input  wire logic              OUT_EN_N_I,
    input  wire logic              SNOOZE_IN_I,
    // shared data pins
    input  wire logic [DATA_W-1:0] DATA_I,
    output logic      [DATA_W-1:0] DATA_O,
    output logic                   DATA_OE_N_O
);
    // captured synchronous inputs
    logic [ADDR_W-1:0] in_addr;      // address pins
    logic              in_cs_n;      // low select
    logic              in_cs2_n;     // second low select
    logic              in_cs_hi;     // high select
    logic              in_ld_n;      // low loads, high advances
    logic              in_rd;        // high reads, low writes
    logic              in_cke_n;     // high suspends
    logic [LANES-1:0]  in_bw_n;      // lane write enables, low active
    logic [DATA_W-1:0] in_data;      // write data pins
    // synchronisers for asynchronous pins
    logic [1:0]        oe_sync;      // output enable, low active
    logic [1:0]        snz_sync;     // snooze
    logic [1:0]        ord_sync;     // burst order
    logic              oe_n_s;
    logic              snooze_s;
    logic              interleave_s;
    // burst and cycle state
    op_e               cur_op;       // cycle kind of the current burst
    logic [ADDR_W-1:0] base_addr;    // loaded base address
    logic [BURST_W-1:0] burst_cnt;   // accesses since the load
    logic [BURST_W-1:0] next_cnt;
    // this cycle's access
    logic              run;          // enabled edge, not in standby, room for reads
    logic              load;
    logic              sel;
    op_e               op_now;
    logic [ADDR_W-1:0] addr_now;
    // write pipeline
    logic              wr1_valid;
    logic [ADDR_W-1:0] wr1_addr;
    logic [LANES-1:0]  wr1_bw_n;
    logic              wr2_valid;
    logic [ADDR_W-1:0] wr2_addr;
    logic [LANES-1:0]  wr2_bw_n;
    // read path
    logic              rd_pend;      // array word lands this edge
    logic              buf_in_ready;
    logic              buf_out_valid;
    logic              drain;        // output slot moves on

    sram_array_if #(.ADDR_W(ADDR_W), .LANES(LANES), .LANE_W(LANE_W)) arr ();

    // burst sequence: xor for interleaved, modulo add for linear
    function automatic logic [BURST_W-1:0] burst_lsb(input logic [BURST_W-1:0] seed,
                                                     input logic [BURST_W-1:0] step,
                                                     input logic              ilv);
        return ilv ? (seed ^ step) : BURST_W'(seed + step);
    endfunction : burst_lsb

    // every synchronous pin is registered before use
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            in_addr  <= '0;
            in_cs_n  <= LEVEL_N_RST;
            in_cs2_n <= LEVEL_N_RST;
            in_cs_hi <= LEVEL_RST;
            in_ld_n  <= LEVEL_N_RST;
            in_rd    <= LEVEL_N_RST;
            in_cke_n <= LEVEL_N_RST;
            in_bw_n  <= '1;
            in_data  <= '0;
        end else begin
            in_addr  <= SYNC_ADDR_I;
            in_cs_n  <= CHIP_SEL_N_I;
            in_cs2_n <= CHIP_SEL2_N_I;
            in_cs_hi <= CHIP_SEL_HI_I;
            in_ld_n  <= LOAD_ADVANCE_N_I;
            in_rd    <= READ_WRITE_N_I;
            in_cke_n <= CLK_EN_N_I;
            in_bw_n  <= BYTE_WR_N_I;
            in_data  <= DATA_I;
        end
    end

    // asynchronous pins pass two flops; only the second stage is read
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            oe_sync  <= 2'h3;
            snz_sync <= 2'h0;
            ord_sync <= 2'h0;
        end else begin
            oe_sync  <= {oe_sync[0], OUT_EN_N_I};
            snz_sync <= {snz_sync[0], SNOOZE_IN_I};
            ord_sync <= {ord_sync[0], BURST_ORDER_I};
        end
    end
    assign oe_n_s       = oe_sync[1];
    assign snooze_s     = snz_sync[1];
    assign interleave_s = ord_sync[1];

    // a suspended or standby edge is ignored whole; the buffer can also hold back
    assign drain = !in_cke_n && !snooze_s;
    assign run   = drain && buf_in_ready;
    assign load  = !in_ld_n;
    assign sel   = !in_cs_n && !in_cs2_n && in_cs_hi;
    assign next_cnt = BURST_W'(burst_cnt + 1'b1);

    // kind and address of this cycle's access
    always_comb begin
        if (load) begin
            if (!sel) begin
                op_now = OP_DESEL;
            end else if (in_rd) begin
                op_now = OP_READ;
            end else begin
                op_now = OP_WRITE;
            end
            addr_now = in_addr;
        end else begin
            op_now   = cur_op;
            addr_now = {base_addr[ADDR_W-1:BURST_W],
                        burst_lsb(base_addr[BURST_W-1:0], next_cnt, interleave_s)};
        end
    end

    // burst state: a load seeds it, an advance steps the counter
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cur_op    <= OP_DESEL;
            base_addr <= '0;
            burst_cnt <= BURST_CNT_RST;
        end else if (run) begin
            if (load) begin
                cur_op    <= op_now;
                base_addr <= in_addr;
                burst_cnt <= BURST_CNT_RST;
            end else begin
                burst_cnt <= next_cnt;
            end
        end
    end

    // write pipeline: lanes travel with the address, data joins two edges on
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            wr1_valid <= LEVEL_RST;
            wr1_addr  <= '0;
            wr1_bw_n  <= '1;
            wr2_valid <= LEVEL_RST;
            wr2_addr  <= '0;
            wr2_bw_n  <= '1;
        end else if (run) begin
            wr1_valid <= (op_now == OP_WRITE);
            wr1_addr  <= addr_now;
            wr1_bw_n  <= in_bw_n;
            wr2_valid <= wr1_valid;
            wr2_addr  <= wr1_addr;
            wr2_bw_n  <= wr1_bw_n;
        end
    end

    // self-timed array write from registered controls and captured data
    assign arr.we    = run && wr2_valid;
    assign arr.waddr = wr2_addr;
    assign arr.wdata = in_data;
    assign arr.be    = ~wr2_bw_n;
    // reads go to the array in the same slot as writes, no turnaround
    assign arr.re    = run && (op_now == OP_READ);
    assign arr.raddr = addr_now;

    // the array word goes out in the slot after the read; a suspended
    // edge holds it back so the read pipe freezes like the write pipe
    always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            rd_pend <= LEVEL_RST;
        end else if (drain) begin
            rd_pend <= arr.re;
        end
    end

    sram_array u_array (
        .clk_i (CORE_CLK_I),
        .port  (arr)
    );

    // buffer head, or the array register while empty, drives the pins; a stalled edge keeps the word
    out_buffer #(.WIDTH(DATA_W), .DEPTH(OUT_BUF_DEPTH)) u_out_buf (
        .clk_i       (CORE_CLK_I),
        .arst_n_i    (ARST_N_I),
        .in_valid_i  (rd_pend && drain),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (arr.rdata),
        .out_valid_o (buf_out_valid),
        .out_ready_i (drain),
        .out_data_o  (DATA_O)
    );

    // drivers on only for a read word, with enable low and not in standby;
    // a tied-low enable works because the turn-on follows the read slot
    assign DATA_OE_N_O = !(buf_out_valid && !oe_n_s && !snooze_s);

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!ARST_N_I);

    AST_CAPTURE: assert property (
        ##1 (in_addr == $past(SYNC_ADDR_I)) && (in_bw_n == $past(BYTE_WR_N_I)))
        else $error("pins not captured on the edge");
    AST_RD_LAT: assert property (
        arr.re ##1 drain |-> rd_pend && buf_out_valid)
        else $error("read word not at output in the slot after the array read");
    AST_WR_LAG: assert property (
        (run && op_now == OP_WRITE) ##1 run ##1 run |-> arr.we && arr.waddr == $past(addr_now, 2))
        else $error("write not applied with data two edges later");
    AST_WRAP: assert property (
        (run && !load && burst_cnt == 2'h3) |=> burst_cnt == 2'h0)
        else $error("burst counter did not wrap after fourth access");
    AST_HOLD: assert property (
        !run |=> $stable(cur_op) && $stable(burst_cnt) && $stable(wr1_valid) && $stable(wr2_valid))
        else $error("state changed while suspended");
    AST_ADV_KIND: assert property (
        (run && !load) |=> cur_op == $past(cur_op))
        else $error("advance cycle changed cycle kind");
    AST_DESEL: assert property (
        (load && !sel) |-> op_now == OP_DESEL && !arr.re)
        else $error("deselected load started an access");
    AST_LANES: assert property (
        (run && op_now == OP_WRITE) ##1 run ##1 run |-> arr.be == ~$past(in_bw_n, 2))
        else $error("lane enables not those given with the address");
    AST_OE: assert property (
        (oe_n_s || !buf_out_valid) |-> DATA_OE_N_O)
        else $error("data drivers on without enable or word");
    AST_SNOOZE: assert property (
        snooze_s |-> !run && DATA_OE_N_O && !arr.we)
        else $error("activity during snooze");

    COV_READ:  cover property (arr.re ##1 !DATA_OE_N_O);
    COV_RW:    cover property (arr.re && arr.we);
    COV_WRAP:  cover property (run && !load && burst_cnt == 2'h3);
    COV_STALL: cover property (buf_out_valid && !drain);
endmodule : sram_port
`default_nettype wire

// ---- bench/bus_side_model.sv ----
/*
 * Far side of the shared data pins: works out the wire level from the
 * device drive and the controller drive and feeds it back to the port.
 * Assumes the bench times the controller drive by enabled edges.
 */
`timescale 1ns/10ps
`default_nettype none
module bus_side_model #(
    parameter int DW = 36
) (
    input  wire logic          clk_i,
    input  wire logic [DW-1:0] dev_data_i,   // device read word
    input  wire logic          dev_oe_n_i,   // low while device drives
    input  wire logic [DW-1:0] host_data_i,  // controller write word
    input  wire logic          host_drive_i, // controller drives the wire
    output logic      [DW-1:0] bus_o         // level seen on the wire
);
    logic [DW-1:0] filler = '0;              // level of a released wire
    // no keeper on these pins, so a released wire must not mimic old data
    always @(posedge clk_i) begin
        filler <= ~bus_o;
    end
    // two drivers at once is contention, never a winner
    always_comb begin
        if (!dev_oe_n_i && host_drive_i) begin
            bus_o = 'x;
        end else if (!dev_oe_n_i) begin
            bus_o = dev_data_i;
        end else if (host_drive_i) begin     // write word in its late slot
            bus_o = host_data_i;
        end else begin
            bus_o = filler;
        end
    end
endmodule : bus_side_model
`default_nettype wire

// ---- bench/pipelined_sync_sram_port_test.sv ----
/*
 * Self-checking bench of the memory port: drives the controller side once
 * per cycle and checks read words and the drive enable.
 * Assumes the port's default geometry: four 9-bit lanes.
 */
`timescale 1ns/10ps
`default_nettype none
module pipelined_sync_sram_port_test;
    import sram_port_pkg::*;
    localparam int LW = BYTE_W + 1;        // lane plus check bit
    localparam int DW = DEF_LANES * LW;
    localparam int AW = DEF_ADDR_W;
    logic          clk = 1'b0;
    logic          arst_n = 1'b0;
    logic [AW-1:0] addr = '0;
    logic [2:0]    sel = 3'h4;             // {sel_n, sel2_n, sel_hi}
    logic          ld_n = 1'b0;
    logic          rw_n = 1'b1;
    logic          cke_n = 1'b1;
    logic [3:0]    bw_n = 4'hf;
    logic          order = 1'b0;
    logic          oe_n = 1'b0;
    logic          snooze = 1'b0;
    logic          ord_v = 1'b0;
    logic          oe_v = 1'b0;            // held on: output timing is self-timed
    logic          zz_v = 1'b0;            // standby unused outside its scenario
    logic [DW-1:0] hdata = '0;
    logic          hdrive = 1'b0;
    logic [DW-1:0] bus;
    logic [DW-1:0] dq_o;
    logic          dq_oe_n;
    int            failures = 0;
    int            n_tests = 0;
    // expected pipe, one slot per enabled edge: kind 1 read, 2 write
    logic [1:0]    pk [3] = '{default: 2'h0};
    logic [DW-1:0] pd [3];
    logic [1:0]    nk = 2'h0;
    logic [DW-1:0] nd;
    logic          last_en = 1'b0;
    logic          live = 1'b1;            // drive enable expected to follow reads
    logic          asleep = 1'b0;
    logic [1:0]    bkind = 2'h0;
    logic [AW-1:0] bbase = '0;
    logic [1:0]    bstep = 2'h0;
    logic [DW-1:0] mem [logic [AW-1:0]];   // reference contents

    initial begin
        forever #2 clk = ~clk;
    end

    sram_port dut (
        .CORE_CLK_I       (clk),
        .ARST_N_I         (arst_n),
        .SYNC_ADDR_I      (addr),
        .CHIP_SEL_N_I     (sel[2]),
        .CHIP_SEL2_N_I    (sel[1]),
        .CHIP_SEL_HI_I    (sel[0]),
        .LOAD_ADVANCE_N_I (ld_n),
        .READ_WRITE_N_I   (rw_n),
        .CLK_EN_N_I       (cke_n),
        .BYTE_WR_N_I      (bw_n),
        .BURST_ORDER_I    (order),
        .OUT_EN_N_I       (oe_n),
        .SNOOZE_IN_I      (snooze),
        .DATA_I           (bus),
        .DATA_O           (dq_o),
        .DATA_OE_N_O      (dq_oe_n)
    );
    bus_side_model #(.DW(DW)) far (
        .clk_i        (clk),
        .dev_data_i   (dq_o),
        .dev_oe_n_i   (dq_oe_n),
        .host_data_i  (hdata),
        .host_drive_i (hdrive),
        .bus_o        (bus)
    );

    task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] want);
        n_tests++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    function automatic logic [DW-1:0] pat(input int i);
        return 36'h9e3779b97 * DW'(i + 1);
    endfunction : pat

    // one bus cycle: l = load_n, r = rw_n (high reads), s = selects, e = clock enable_n
    task automatic step(input logic l, input logic r, input logic [2:0] s, input logic [AW-1:0] a,
                        input logic [3:0] b, input logic [DW-1:0] d, input logic e);
        logic [1:0]    k;
        logic [AW-1:0] ea;
        logic [DW-1:0] m;
        @(posedge clk);
        if (last_en) begin                 // the edge just taken moved the pipe
            pk[2] = pk[1];
            pd[2] = pd[1];
            pk[1] = pk[0];
            pd[1] = pd[0];
            pk[0] = nk;
            pd[0] = nd;
        end
        hdrive <= (pk[1] == 2'h2);         // second enabled edge after address
        hdata <= pd[1];
        {ld_n, rw_n, sel, addr, bw_n, cke_n} <= {l, r, s, a, b, e}; // enables go with address
        {order, oe_n, snooze} <= {ord_v, oe_v, zz_v};
        for (int g = 0; g < 4; g++) begin
            m[g*LW +: LW] = {LW{!b[g]}};
        end
        ea = a;
        k = 2'h0;
        if (!e && !asleep && l) begin      // advance keeps the loaded kind
            bstep = bstep + 2'h1;
            ea = {bbase[AW-1:2], ord_v ? bbase[1:0] ^ bstep : bbase[1:0] + bstep};
            k = bkind;
        end else if (!e && !asleep) begin  // load: the only place kind is decoded
            bbase = a;
            bstep = 2'h0;
            k = (s == 3'h1) ? (r ? 2'h1 : 2'h2) : 2'h0;
            bkind = k;
        end
        if (k == 2'h2) mem[ea] = (mem[ea] & ~m) | (d & m);
        nk = k;
        nd = (k == 2'h1) ? mem[ea] : d;
        last_en = !e && !asleep;
        @(negedge clk);
        if (live) begin
            check(dq_oe_n, pk[1] != 2'h1);
            if (pk[1] == 2'h1) check(dq_o, pd[1]);
        end else begin
            check(dq_oe_n, 1'b1);
        end
    endtask : step

    task automatic idle(input int n);
        repeat (n) step(1'b0, 1'b1, 3'h4, '0, 4'hf, '0, 1'b0);
    endtask : idle
    task automatic wr(input int a, input logic [3:0] b, input logic [DW-1:0] d);
        step(1'b0, 1'b0, 3'h1, AW'(a), b, d, 1'b0);
    endtask : wr
    task automatic rd(input int a);
        step(1'b0, 1'b1, 3'h1, AW'(a), 4'hf, '0, 1'b0);
    endtask : rd

    // fresh address each access, reads and writes interleaved with no gap
    task automatic t_mix();
        for (int i = 0; i < 8; i++) wr(i, 4'h0, pat(i));
        idle(3);
        for (int i = 0; i < 4; i++) begin
            rd(i);
            wr(i + 8, 4'h0, pat(i + 8));
        end
        for (int i = 0; i < 12; i++) rd(i);
        idle(3);
    endtask : t_mix

    // one to four lanes written over a zero word
    task automatic t_lanes();
        for (int g = 0; g < 4; g++) wr(32 + g, 4'h0, '0);
        for (int g = 0; g < 4; g++) wr(32 + g, 4'hf << (g + 1), '1);
        idle(2);
        for (int g = 0; g < 4; g++) rd(32 + g);
        idle(3);
    endtask : t_lanes

    // base 1 tells linear from interleaved; read burst runs past the wrap
    task automatic t_burst(input logic o);
        ord_v = o;
        idle(3);
        wr(65, 4'h0, pat(20));
        for (int k = 1; k < 4; k++) step(1'b1, 1'b1, 3'h4, '0, 4'h0, pat(20 + k), 1'b0);
        idle(2);
        for (int a = 64; a < 68; a++) rd(a);
        rd(65);
        for (int k = 1; k < 5; k++) step(1'b1, 1'b0, 3'h4, '0, 4'h0, '0, 1'b0);
        idle(3);
    endtask : t_burst

    // each select off in turn, then an advance after the deselect
    task automatic t_desel();
        wr(80, 4'h0, pat(30));
        for (int i = 0; i < 3; i++) step(1'b0, 1'b0, 3'h1 ^ (3'h4 >> i), AW'(80), 4'h0, pat(31 + i), 1'b0);
        step(1'b1, 1'b0, 3'h1, AW'(80), 4'h0, pat(35), 1'b0);
        idle(2);
        rd(80);
        idle(3);
    endtask : t_desel

    // suspended edges drop their request and freeze the pipe
    task automatic t_suspend();
        wr(4, 4'h0, pat(40));
        step(1'b0, 1'b0, 3'h1, AW'(5), 4'h0, pat(41), 1'b1);
        wr(6, 4'h0, pat(42));
        idle(3);
        rd(4);
        for (int i = 0; i < 2; i++) step(1'b0, 1'b1, 3'h1, AW'(5), 4'hf, '0, 1'b1);
        rd(5);
        rd(6);
        idle(3);
    endtask : t_suspend

    // output enable off hides a read word
    task automatic t_oe();
        oe_v = 1'b1;
        live = 1'b0;
        idle(2);
        rd(0);
        idle(4);
        oe_v = 1'b0;
        idle(3);
        live = 1'b1;
    endtask : t_oe

    // standby drops requests and leaves contents alone
    task automatic t_snooze();
        wr(7, 4'h0, pat(49));              // known word to survive standby
        idle(3);
        zz_v = 1'b1;
        live = 1'b0;
        idle(3);
        asleep = 1'b1;
        wr(7, 4'h0, pat(50));
        idle(2);
        zz_v = 1'b0;
        idle(3);
        asleep = 1'b0;
        live = 1'b1;
        rd(7);
        idle(3);
    endtask : t_snooze

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        idle(3);
        t_mix();
        t_lanes();
        t_burst(1'b0);
        t_burst(1'b1);
        t_desel();
        t_suspend();
        t_oe();
        t_snooze();
        test_done();
    end

    // bound on the whole run, in case the sequence hangs
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule : pipelined_sync_sram_port_test
`default_nettype wire
